// File: flash_cfg_pkg.sv
// Shared constants and types for the parallel flash configuration master
package flash_cfg_pkg;
  localparam int DATA_W = 16;
  localparam int ADDR_W = 24;
  localparam int TMR_W = 16;
  localparam int WCNT_W = 24;
  localparam int OSC_MHZ = 40;
  localparam int OSC_PERIOD_NS = 1000 / OSC_MHZ;
  localparam int CLK_MHZ = 25;
  localparam int CLK_PERIOD_NS = 1000 / CLK_MHZ;
  localparam int HARD_RESET_NS = 100;
  localparam int RECOVER_NS = 150;
  localparam int WRITE_PULSE_NS = 50;
  localparam int REQ_LOW_NS = 500;
  // Least times, rounded up to whole link cycles
  localparam int HARD_RESET_CYC =
    (HARD_RESET_NS + OSC_PERIOD_NS - 1) / OSC_PERIOD_NS;
  localparam int RECOVER_CYC = (RECOVER_NS + OSC_PERIOD_NS - 1) / OSC_PERIOD_NS;
  localparam int WRITE_PULSE_CYC =
    (WRITE_PULSE_NS + OSC_PERIOD_NS - 1) / OSC_PERIOD_NS;
  localparam int REQ_LOW_CYC = (REQ_LOW_NS + OSC_PERIOD_NS - 1) / OSC_PERIOD_NS;
  localparam int LATENCY_CYC = 4;
  localparam logic [DATA_W-1:0] CMD_CFG_SETUP = 16'h0060;
  localparam logic [DATA_W-1:0] CMD_CFG_CONFIRM = 16'h0003;
  localparam logic [ADDR_W-1:0] SYNC_CFG_ADDR = 24'h00C943;
  localparam logic [ADDR_W-1:0] IMAGE_START = 24'h000000;
  localparam int OWN_WORDS = 65536;

  typedef struct packed {
    logic hard_reset_n;
    logic chip_select_n;
    logic output_enable_n;
    logic address_valid_strobe_n;
    logic write_strobe_n;
  } flash_ctrl_s;

  localparam flash_ctrl_s CTRL_IDLE = 5'h1F;

  typedef enum logic [3:0] {
    ST_IDLE,
    ST_HOLD_RESET,
    ST_RECOVER,
    ST_CMD_SETUP,
    ST_CMD_STROBE,
    ST_CMD_GAP,
    ST_BURST_ADDR,
    ST_BURST_WAIT,
    ST_BURST_READ,
    ST_DONE
  } link_state_e;
endpackage : flash_cfg_pkg

// File: parallel_flash_config_master.sv
// Active parallel configuration master fetching its image from NOR flash
// Summary of operation
// - Read 16-bit words from flash into configuration memory
// - This device generates all interface timing and sequencing
// - Fetch the image with one continuous synchronous burst read
// - Configuration clock comes from the internal 40 MHz oscillator
// - Configuration clock is never faster than the 40 MHz oscillator
// - Drive a 24-bit word address onto flash address inputs
// - Bidirectional 16-bit data bus, flash drives reads, device writes
// - Drive clock, hard reset, select, output enable, strobes
// - Flash ready indication ignored during configuration, visible after
// - Flash starts asynchronous; writes asynchronous until sync mode set
// - Sample each synchronous word on rising configuration clock edge
// - Configuration clock times the whole cycle and every transfer
// - Release the flash to user logic after configuration
// - Drive chain enable output low once own data captured
// - Last chain enable output may be unused after configuration
// - Shared request, status, done, clock and data; first is master
// - Slaves sit byte-wide on low lane or word-wide on both
// - Release shared done line after own data; high starts init
`timescale 1ns/1ps
module parallel_flash_config_master #(
  parameter int OWN_WORDS = flash_cfg_pkg::OWN_WORDS,
  parameter logic [flash_cfg_pkg::ADDR_W-1:0] START_ADDR =
    flash_cfg_pkg::IMAGE_START
) (
  // System clock and reset
  input wire logic clock_in,
  input wire logic reset_n_in,
  // Internal configuration oscillator
  input wire logic osc_clk_in,
  // Configuration control pins
  input wire logic config_request_n_in,
  input wire logic chain_enable_n_in,
  output logic chain_enable_out_n_out,
  input wire logic shared_status_n_in,
  output logic shared_status_n_out,
  output logic shared_status_oe_out,
  input wire logic config_complete_in,
  output logic config_complete_out,
  output logic config_complete_oe_out,
  // Flash interface
  output logic config_clock_out,
  output logic bus_oe_out,
  output flash_cfg_pkg::flash_ctrl_s flash_ctrl_out,
  output logic [flash_cfg_pkg::ADDR_W-1:0] flash_addr_out,
  input wire logic [flash_cfg_pkg::DATA_W-1:0] flash_data_in,
  output logic [flash_cfg_pkg::DATA_W-1:0] flash_data_out,
  output logic flash_data_oe_out,
  input wire logic flash_ready_in,
  // Configuration memory, oscillator domain
  output logic [flash_cfg_pkg::DATA_W-1:0] cfg_word_out,
  output logic cfg_write_out,
  // Status, system clock domain
  output logic config_done_out,
  output logic init_start_out,
  output logic flash_ready_user_out
);
  localparam logic [flash_cfg_pkg::WCNT_W-1:0] OWN_LAST =
    flash_cfg_pkg::WCNT_W'(OWN_WORDS - 1);

  // Pin synchronisers, oscillator domain
  logic rst_s1_q, rst_s2_q;
  logic req_s1_q, req_s2_q;
  logic cen_s1_q, cen_s2_q;
  logic sts_s1_q, sts_s2_q;
  logic cpl_s1_q, cpl_s2_q;

  always_ff @(posedge osc_clk_in)
  begin
    rst_s1_q <= reset_n_in;
    rst_s2_q <= rst_s1_q;
    req_s1_q <= config_request_n_in;
    req_s2_q <= req_s1_q;
    cen_s1_q <= chain_enable_n_in;
    cen_s2_q <= cen_s1_q;
    sts_s1_q <= shared_status_n_in;
    sts_s2_q <= sts_s1_q;
    cpl_s1_q <= config_complete_in;
    cpl_s2_q <= cpl_s1_q;
  end

  wire link_rst_n = rst_s2_q;
  wire float_req = cen_s2_q && !req_s2_q;

  // Link state
  flash_cfg_pkg::link_state_e state_q, state_d;
  logic [flash_cfg_pkg::TMR_W-1:0] tmr_q, tmr_d;
  logic [flash_cfg_pkg::TMR_W-1:0] req_low_q, req_low_d;
  logic [flash_cfg_pkg::WCNT_W-1:0] words_q, words_d;
  logic [flash_cfg_pkg::ADDR_W-1:0] addr_q, addr_d;
  logic [flash_cfg_pkg::DATA_W-1:0] dout_q, dout_d;
  logic [flash_cfg_pkg::DATA_W-1:0] word_q, word_d;
  flash_cfg_pkg::flash_ctrl_s ctrl_q, ctrl_d;
  logic cmd_idx_q, cmd_idx_d;
  logic sync_mode_q, sync_mode_d;
  logic dout_oe_q, dout_oe_d;
  logic bus_oe_q, bus_oe_d;
  logic wr_q, wr_d;
  logic chain_n_q, chain_n_d;
  logic cpl_oe_q, cpl_oe_d;
  logic sts_oe_q, sts_oe_d;
  logic done_q, done_d;

  always_comb
  begin
    state_d = state_q;
    tmr_d = tmr_q;
    words_d = words_q;
    addr_d = addr_q;
    dout_d = dout_q;
    word_d = word_q;
    ctrl_d = ctrl_q;
    cmd_idx_d = cmd_idx_q;
    sync_mode_d = sync_mode_q;
    dout_oe_d = 1'b0;
    bus_oe_d = bus_oe_q;
    wr_d = 1'b0;
    chain_n_d = chain_n_q;
    cpl_oe_d = cpl_oe_q;
    sts_oe_d = 1'b0;
    done_d = done_q;
    req_low_d = req_s2_q ? '0 :
      (req_low_q == flash_cfg_pkg::TMR_W'(flash_cfg_pkg::REQ_LOW_CYC)) ?
      req_low_q : req_low_q + 1'b1;
    case (state_q)
      flash_cfg_pkg::ST_IDLE:
      begin
        ctrl_d = flash_cfg_pkg::CTRL_IDLE;
        sync_mode_d = 1'b0;
        words_d = '0;
        chain_n_d = 1'b1;
        cpl_oe_d = 1'b1;
        done_d = 1'b0;
        sts_oe_d = !req_s2_q;
        // stay off the bus while floated
        bus_oe_d = 1'b0;
        // Own status drive must clear first, else it aborts the start
        if (req_s2_q && !cen_s2_q && sts_s2_q)
        begin
          state_d = flash_cfg_pkg::ST_HOLD_RESET;
          bus_oe_d = 1'b1;
          ctrl_d.hard_reset_n = 1'b0;
          tmr_d = flash_cfg_pkg::TMR_W'(flash_cfg_pkg::HARD_RESET_CYC - 1);
        end
      end
      flash_cfg_pkg::ST_HOLD_RESET:
      begin
        if (tmr_q == '0)
        begin
          state_d = flash_cfg_pkg::ST_RECOVER;
          ctrl_d.hard_reset_n = 1'b1;
          tmr_d = flash_cfg_pkg::TMR_W'(flash_cfg_pkg::RECOVER_CYC - 1);
        end
        else
          tmr_d = tmr_q - 1'b1;
      end
      flash_cfg_pkg::ST_RECOVER:
      begin
        if (tmr_q == '0)
        begin
          state_d = flash_cfg_pkg::ST_CMD_SETUP;
          cmd_idx_d = 1'b0;
        end
        else
          tmr_d = tmr_q - 1'b1;
      end
      flash_cfg_pkg::ST_CMD_SETUP:
      begin
        // asynchronous write to enter sync read mode
        state_d = flash_cfg_pkg::ST_CMD_STROBE;
        addr_d = flash_cfg_pkg::SYNC_CFG_ADDR;
        dout_d = cmd_idx_q ? flash_cfg_pkg::CMD_CFG_CONFIRM :
          flash_cfg_pkg::CMD_CFG_SETUP;
        dout_oe_d = 1'b1;
        ctrl_d.chip_select_n = 1'b0;
        ctrl_d.address_valid_strobe_n = 1'b0;
        ctrl_d.write_strobe_n = 1'b0;
        tmr_d = flash_cfg_pkg::TMR_W'(flash_cfg_pkg::WRITE_PULSE_CYC - 1);
      end
      flash_cfg_pkg::ST_CMD_STROBE:
      begin
        // device drives data only while writing
        dout_oe_d = 1'b1;
        ctrl_d.address_valid_strobe_n = 1'b1;
        if (tmr_q == '0)
        begin
          state_d = flash_cfg_pkg::ST_CMD_GAP;
          ctrl_d.write_strobe_n = 1'b1;
        end
        else
          tmr_d = tmr_q - 1'b1;
      end
      flash_cfg_pkg::ST_CMD_GAP:
      begin
        ctrl_d.chip_select_n = 1'b1;
        if (cmd_idx_q)
        begin
          state_d = flash_cfg_pkg::ST_BURST_ADDR;
          sync_mode_d = 1'b1;
          addr_d = START_ADDR;
          ctrl_d.chip_select_n = 1'b0;
          ctrl_d.address_valid_strobe_n = 1'b0;
        end
        else
        begin
          state_d = flash_cfg_pkg::ST_CMD_SETUP;
          cmd_idx_d = 1'b1;
        end
      end
      flash_cfg_pkg::ST_BURST_ADDR:
      begin
        // single burst, output enable held to the end
        state_d = flash_cfg_pkg::ST_BURST_WAIT;
        ctrl_d.address_valid_strobe_n = 1'b1;
        ctrl_d.output_enable_n = 1'b0;
        tmr_d = flash_cfg_pkg::TMR_W'(flash_cfg_pkg::LATENCY_CYC - 1);
      end
      flash_cfg_pkg::ST_BURST_WAIT:
      begin
        // fixed latency, ready indication not used
        if (tmr_q == '0)
          state_d = flash_cfg_pkg::ST_BURST_READ;
        else
          tmr_d = tmr_q - 1'b1;
      end
      flash_cfg_pkg::ST_BURST_READ:
      begin
        // one word per rising clock edge
        word_d = flash_data_in;
        addr_d = addr_q + 1'b1;
        if (chain_n_q)
        begin
          // own words go to configuration memory
          wr_d = 1'b1;
          words_d = words_q + 1'b1;
          if (words_q == OWN_LAST)
          begin
            chain_n_d = 1'b0;
            cpl_oe_d = 1'b0;
          end
        end
        // keep feeding slaves until the chain is done
        if (!chain_n_q && cpl_s2_q)
        begin
          state_d = flash_cfg_pkg::ST_DONE;
          ctrl_d = flash_cfg_pkg::CTRL_IDLE;
        end
      end
      flash_cfg_pkg::ST_DONE:
      begin
        // hand the flash pins to user logic
        bus_oe_d = 1'b0;
        done_d = 1'b1;
      end
      default:
        state_d = flash_cfg_pkg::ST_IDLE;
    endcase
    // abort on long request low or status error
    if (state_q != flash_cfg_pkg::ST_IDLE &&
        (req_low_q == flash_cfg_pkg::TMR_W'(flash_cfg_pkg::REQ_LOW_CYC) ||
         (!sts_s2_q && state_q != flash_cfg_pkg::ST_DONE)))
    begin
      state_d = flash_cfg_pkg::ST_IDLE;
      bus_oe_d = 1'b0;
      ctrl_d = flash_cfg_pkg::CTRL_IDLE;
      dout_oe_d = 1'b0;
      wr_d = 1'b0;
    end
  end

  // every link register runs on the oscillator
  always_ff @(posedge osc_clk_in)
  begin
    if (!link_rst_n)
    begin
      state_q <= flash_cfg_pkg::ST_IDLE;
      tmr_q <= '0;
      req_low_q <= '0;
      words_q <= '0;
      addr_q <= '0;
      dout_q <= '0;
      word_q <= '0;
      ctrl_q <= flash_cfg_pkg::CTRL_IDLE;
      cmd_idx_q <= 1'b0;
      sync_mode_q <= 1'b0;
      dout_oe_q <= 1'b0;
      bus_oe_q <= 1'b0;
      wr_q <= 1'b0;
      chain_n_q <= 1'b1;
      cpl_oe_q <= 1'b1;
      sts_oe_q <= 1'b0;
      done_q <= 1'b0;
    end
    else
    begin
      state_q <= state_d;
      tmr_q <= tmr_d;
      req_low_q <= req_low_d;
      words_q <= words_d;
      addr_q <= addr_d;
      dout_q <= dout_d;
      word_q <= word_d;
      ctrl_q <= ctrl_d;
      cmd_idx_q <= cmd_idx_d;
      sync_mode_q <= sync_mode_d;
      dout_oe_q <= dout_oe_d;
      bus_oe_q <= bus_oe_d;
      wr_q <= wr_d;
      chain_n_q <= chain_n_d;
      cpl_oe_q <= cpl_oe_d;
      sts_oe_q <= sts_oe_d;
      done_q <= done_d;
    end
  end

  // Glitch-free clock gate, enable moves while oscillator is low
  logic gate_q, gate_d;
  always_comb
  begin
    gate_d = bus_oe_q && state_q != flash_cfg_pkg::ST_DONE;
  end
  always_ff @(negedge osc_clk_in)
  begin
    if (!link_rst_n)
      gate_q <= 1'b0;
    else
      gate_q <= gate_d;
  end
  // never faster than the oscillator itself
  assign config_clock_out = osc_clk_in & gate_q;

  assign bus_oe_out = bus_oe_q;
  assign flash_ctrl_out = ctrl_q;
  assign flash_addr_out = addr_q;
  assign flash_data_out = dout_q;
  assign flash_data_oe_out = dout_oe_q;
  assign cfg_word_out = word_q;
  assign cfg_write_out = wr_q;
  // chain output stays driven low from chain_n_q after the chain is done
  assign chain_enable_out_n_out = chain_n_q;
  assign config_complete_out = 1'b0;
  assign config_complete_oe_out = cpl_oe_q;
  assign shared_status_n_out = 1'b0;
  assign shared_status_oe_out = sts_oe_q;

  // System domain: done level, done line and ready crossings
  logic dn_s1_q, dn_s2_q;
  logic cp_s1_q, cp_s2_q;
  logic rd_s1_q, rd_s2_q;
  logic cp_prev_q, cp_prev_d;
  logic done_o_q, done_o_d;
  logic init_q, init_d;
  logic rdy_q, rdy_d;

  always_ff @(posedge clock_in)
  begin
    dn_s1_q <= done_q;
    dn_s2_q <= dn_s1_q;
    cp_s1_q <= config_complete_in;
    cp_s2_q <= cp_s1_q;
    rd_s1_q <= flash_ready_in;
    rd_s2_q <= rd_s1_q;
  end

  always_comb
  begin
    cp_prev_d = cp_s2_q;
    done_o_d = dn_s2_q;
    init_d = cp_s2_q && !cp_prev_q;
    // ready visible to user logic only after configuration
    rdy_d = dn_s2_q && rd_s2_q;
  end

  always_ff @(posedge clock_in)
  begin
    if (!reset_n_in)
    begin
      cp_prev_q <= 1'b0;
      done_o_q <= 1'b0;
      init_q <= 1'b0;
      rdy_q <= 1'b0;
    end
    else
    begin
      cp_prev_q <= cp_prev_d;
      done_o_q <= done_o_d;
      init_q <= init_d;
      rdy_q <= rdy_d;
    end
  end

  assign config_done_out = done_o_q;
  assign init_start_out = init_q;
  assign flash_ready_user_out = rdy_q;

  // Checks on the link logic
  AST_FLOAT_IDLE: assert property (
    @(posedge osc_clk_in) disable iff (!link_rst_n)
    state_q == flash_cfg_pkg::ST_IDLE && float_req |=> !bus_oe_q)
    else $error("bus driven while floated");
  AST_WRITE_PULSE: assert property (
    @(posedge osc_clk_in) disable iff (!link_rst_n)
    $fell(ctrl_q.write_strobe_n) |->
    !ctrl_q.write_strobe_n [*2] ##1 ctrl_q.write_strobe_n)
    else $error("write strobe width wrong");
  AST_NO_CONTENTION: assert property (
    @(posedge osc_clk_in) disable iff (!link_rst_n)
    !ctrl_q.output_enable_n |-> !dout_oe_q)
    else $error("data bus driven by both ends");
  AST_SYNC_FIRST: assert property (
    @(posedge osc_clk_in) disable iff (!link_rst_n)
    state_q == flash_cfg_pkg::ST_BURST_ADDR |->
    sync_mode_q && $past(cmd_idx_q))
    else $error("burst before sync mode set");
  AST_CAPTURE: assert property (
    @(posedge osc_clk_in) disable iff (!link_rst_n)
    state_q == flash_cfg_pkg::ST_BURST_READ && chain_n_q &&
    state_d == flash_cfg_pkg::ST_BURST_READ |=>
    wr_q && word_q == $past(flash_data_in))
    else $error("burst word not captured");
  AST_ADDR_UP: assert property (
    @(posedge osc_clk_in) disable iff (!link_rst_n)
    state_q == flash_cfg_pkg::ST_BURST_READ &&
    state_d == flash_cfg_pkg::ST_BURST_READ |=>
    addr_q == $past(addr_q) + 1'b1)
    else $error("burst address not increasing");
  AST_CHAIN_OUT: assert property (
    @(posedge osc_clk_in) disable iff (!link_rst_n)
    state_q == flash_cfg_pkg::ST_BURST_READ && chain_n_q &&
    words_q == OWN_LAST && state_d == flash_cfg_pkg::ST_BURST_READ |=>
    !chain_n_q && !cpl_oe_q)
    else $error("chain enable not passed on");
  AST_ABORT: assert property (
    @(posedge osc_clk_in) disable iff (!link_rst_n)
    !req_s2_q [*8] ##0 (req_low_q ==
      flash_cfg_pkg::TMR_W'(flash_cfg_pkg::REQ_LOW_CYC)) |=>
    state_q == flash_cfg_pkg::ST_IDLE)
    else $error("long request low did not abort");
  AST_CLOCK_STOP: assert property (
    @(posedge osc_clk_in) disable iff (!link_rst_n)
    state_q == flash_cfg_pkg::ST_DONE |-> ##1 !bus_oe_q && !gate_q)
    else $error("flash not released after configuration");
endmodule : parallel_flash_config_master

// File: flash_model.sv
// Partner model: parallel NOR flash plus one chained slave
`timescale 1ns/1ps
module flash_model #(
  parameter int SLAVE_CYC = 30
) (
  // Pins driven by the master
  input wire logic config_clock_in,
  input wire flash_cfg_pkg::flash_ctrl_s ctrl_in,
  input wire logic [flash_cfg_pkg::ADDR_W-1:0] addr_in,
  input wire logic [flash_cfg_pkg::DATA_W-1:0] data_in,
  input wire logic chain_n_in,
  // Flash data and slave done hold
  output logic [flash_cfg_pkg::DATA_W-1:0] data_out,
  output logic sync_out,
  output logic slave_hold_out
);
  logic pend;
  // 24 address bits, no extra upper line
  logic [flash_cfg_pkg::ADDR_W-1:0] ptr;
  int lat;
  int scnt;
  initial
  begin
    data_out = 16'hA5A5;
    sync_out = 1'b0;
    pend = 1'b0;
    ptr = 24'h000000;
    lat = 0;
    scnt = 0;
    slave_hold_out = 1'b1;
  end
  always @(posedge ctrl_in.write_strobe_n or negedge ctrl_in.hard_reset_n)
  begin
    if (!ctrl_in.hard_reset_n)
    begin
      sync_out <= 1'b0;
      pend <= 1'b0;
    end
    else if (!ctrl_in.chip_select_n)
    begin
      pend <= (data_in === flash_cfg_pkg::CMD_CFG_SETUP);
      if (pend && data_in === flash_cfg_pkg::CMD_CFG_CONFIRM &&
          addr_in === flash_cfg_pkg::SYNC_CFG_ADDR)
        sync_out <= 1'b1;
    end
  end
  always @(posedge config_clock_in)
  begin
    if (!ctrl_in.chip_select_n && !ctrl_in.address_valid_strobe_n)
    begin
      ptr <= addr_in;
      lat <= 0;
    end
    else if (!ctrl_in.chip_select_n && !ctrl_in.output_enable_n && sync_out)
    begin
      lat <= lat + 1;
      if (lat >= flash_cfg_pkg::LATENCY_CYC - 1)
      begin
        data_out <= #2 ptr[15:0] ^ 16'h5A3C;
        ptr <= ptr + 24'h000001;
      end
      else
        data_out <= #2 ~data_out;
    end
    else
      data_out <= #2 ~data_out;
  end
  // released bus shows no stale word
  always @(posedge ctrl_in.output_enable_n)
    data_out <= ~data_out;
  // slave stands in passive parallel mode
  // slave holds done until its words pass
  always @(posedge config_clock_in or posedge chain_n_in)
  begin
    if (chain_n_in)
    begin
      scnt <= 0;
      slave_hold_out <= 1'b1;
    end
    else if (scnt == SLAVE_CYC)
      slave_hold_out <= 1'b0;
    else
      scnt <= scnt + 1;
  end
endmodule : flash_model

// File: testbench.sv
// Self-checking bench for the parallel flash configuration master
`timescale 1ns/1ps
module testbench;
  localparam int WORDS = 16;
  localparam logic [23:0] START = 24'h000100;
  logic clock_in, reset_n_in, osc_clk, req_n, chain_n, stat_low, ready;
  logic status_line, done_line, chain_out_n, status_n_out, status_oe;
  logic done_out, done_oe, cfg_clk, bus_oe, data_oe, cfg_write;
  logic config_done, init_start, ready_user, sync, slave_hold;
  flash_cfg_pkg::flash_ctrl_s ctrl;
  logic [23:0] addr;
  logic [15:0] data_out, dq, mdq, cfg_word;
  logic [15:0] cfg_q[$];
  logic saw_rst;
  int fails, tests_run, inits;

  assign status_line = !status_oe && !stat_low;
  assign done_line = !done_oe && !slave_hold;
  assign dq = data_oe ? data_out : mdq;

  parallel_flash_config_master #(.OWN_WORDS(WORDS), .START_ADDR(START))
    parallel_flash_config_master_i (
    .clock_in(clock_in), .reset_n_in(reset_n_in), .osc_clk_in(osc_clk),
    .config_request_n_in(req_n), .chain_enable_n_in(chain_n),
    .chain_enable_out_n_out(chain_out_n), .shared_status_n_in(status_line),
    .shared_status_n_out(status_n_out), .shared_status_oe_out(status_oe),
    .config_complete_in(done_line), .config_complete_out(done_out),
    .config_complete_oe_out(done_oe), .config_clock_out(cfg_clk),
    .bus_oe_out(bus_oe), .flash_ctrl_out(ctrl), .flash_addr_out(addr),
    .flash_data_in(dq), .flash_data_out(data_out),
    .flash_data_oe_out(data_oe), .flash_ready_in(ready),
    .cfg_word_out(cfg_word), .cfg_write_out(cfg_write),
    .config_done_out(config_done), .init_start_out(init_start),
    .flash_ready_user_out(ready_user));

  flash_model flash_model_i (
    .config_clock_in(cfg_clk), .ctrl_in(ctrl), .addr_in(addr),
    .data_in(dq), .chain_n_in(chain_out_n), .data_out(mdq),
    .sync_out(sync), .slave_hold_out(slave_hold));

  initial
  begin
    clock_in = 1'b0;
    forever #20 clock_in = ~clock_in;
  end
  initial
  begin
    osc_clk = 1'b0;
    #3.7;
    forever #6 osc_clk = ~osc_clk;
  end
  always @(negedge osc_clk)
  begin
    if (cfg_write === 1'b1)
      cfg_q.push_back(cfg_word);
    if (bus_oe === 1'b1 && ctrl.hard_reset_n === 1'b0)
      saw_rst = 1'b1;
  end
  always @(negedge clock_in)
    if (init_start === 1'b1)
      inits++;

  function automatic logic [15:0] pat(input logic [23:0] a);
    return a[15:0] ^ 16'h5A3C;
  endfunction : pat

  task chk_bit(input string nm, input logic exp, input logic got);
    tests_run++;
    if (got !== exp)
    begin
      fails++;
      $display("MISMATCH %s expected %b seen %b", nm, exp, got);
    end
  endtask : chk_bit

  task chk_word(input string nm, input logic [15:0] exp,
                input logic [15:0] got);
    tests_run++;
    if (got !== exp)
    begin
      fails++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk_word

  task summarize;
    if (fails == 0 && tests_run > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : summarize

  task t_float;
    repeat (20) @(posedge clock_in);
    chk_bit("bus_oe_float", 1'b0, bus_oe);
    chk_bit("status_oe_idle", 1'b1, status_oe);
    req_n <= 1'b1;
    repeat (20) @(posedge clock_in);
    chk_bit("bus_oe_chain_high", 1'b0, bus_oe);
    chk_bit("data_oe_float", 1'b0, data_oe);
  endtask : t_float

  task t_config;
    int i;
    cfg_q.delete();
    saw_rst = 1'b0;
    ready <= 1'b1;
    chain_n <= 1'b0;
    for (i = 0; i < 100 && cfg_q.size() < WORDS; i++)
      @(posedge clock_in);
    chk_bit("hard_reset_pulse", 1'b1, saw_rst);
    chk_bit("flash_sync_mode", 1'b1, sync);
    for (i = 0; i < WORDS; i++)
      chk_word("cfg_word", pat(START + 24'(i)), cfg_q[i]);
    repeat (2) @(posedge clock_in);
    chk_bit("chain_out_low", 1'b0, chain_out_n);
    chk_bit("done_released", 1'b0, done_oe);
    chk_bit("done_waits_slave", 1'b0, config_done);
    chk_bit("ready_ignored", 1'b0, ready_user);
    for (i = 0; i < 50 && config_done !== 1'b1; i++)
      @(posedge clock_in);
    repeat (4) @(posedge clock_in);
    chk_bit("config_done", 1'b1, config_done);
    chk_word("init_pulses", 16'h0001, 16'(inits));
    chk_word("own_word_count", 16'(WORDS), 16'(cfg_q.size()));
    chk_bit("bus_released", 1'b0, bus_oe);
    chk_bit("clock_stopped", 1'b0, cfg_clk);
    chk_bit("ready_user_hi", 1'b1, ready_user);
    ready <= 1'b0;
    repeat (4) @(posedge clock_in);
    chk_bit("ready_user_lo", 1'b0, ready_user);
  endtask : t_config

  task t_abort(input bit by_status);
    int i;
    req_n <= 1'b0;
    chain_n <= 1'b0;
    repeat (10) @(posedge clock_in);
    chk_bit("status_oe_idle", 1'b1, status_oe);
    cfg_q.delete();
    req_n <= 1'b1;
    for (i = 0; i < 100 && cfg_q.size() < 4; i++)
      @(posedge clock_in);
    chk_bit("chain_out_held", 1'b1, chain_out_n);
    if (by_status)
      stat_low <= 1'b1;
    else
      req_n <= 1'b0;
    for (i = 0; i < 40 && bus_oe !== 1'b0; i++)
      @(posedge clock_in);
    chk_bit("abort_float", 1'b0, bus_oe);
    @(posedge clock_in);
    chk_bit("abort_chain_reset", 1'b1, chain_out_n);
    chk_bit("abort_done_held", 1'b1, done_oe);
    chain_n <= 1'b1;
    repeat (2) @(posedge clock_in);
    stat_low <= 1'b0;
  endtask : t_abort

  initial
  begin
    #200000;
    fails++;
    summarize();
  end

  initial
  begin
    reset_n_in = 1'b0;
    req_n = 1'b0;
    chain_n = 1'b1;
    stat_low = 1'b0;
    ready = 1'b0;
    fails = 0;
    tests_run = 0;
    inits = 0;
    saw_rst = 1'b0;
    repeat (5) @(posedge clock_in);
    chk_bit("reset_chain_out", 1'b1, chain_out_n);
    chk_bit("reset_bus_oe", 1'b0, bus_oe);
    reset_n_in <= 1'b1;
    t_float();
    t_config();
    t_abort(1'b0);
    t_abort(1'b1);
    summarize();
  end
endmodule : testbench
